// ===== link_event_pkg.sv
// Constants for the data link event flag block
package link_event_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 7;

  // Register offsets
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h06;
  localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h07;
  localparam logic [ADDR_W-1:0] DETECT_CTRL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] DETECT_VIEW_OFS = 8'h09;

  // Flag positions, shared by status and enable
  localparam int TX_BEGIN_BIT = 6;
  localparam int RX_BEGIN_BIT = 5;
  localparam int TX_END_BIT = 4;
  localparam int RX_END_BIT = 3;
  localparam int FCS_FAULT_BIT = 2;
  localparam int ABORT_BIT = 1;
  localparam int IDLE_BIT = 0;

  // Detector control fields
  localparam int DETECT_EN_BIT = 0;

  // Values after reset
  localparam logic [FLAG_W-1:0] STATUS_RST = 7'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RST = 7'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic DETECT_EN_RST = 1'b1;

  // Serial detector figures
  localparam int ONES_W = 4;
  localparam logic [ONES_W-1:0] ABORT_ONES = 4'h7;
  localparam logic [ONES_W-1:0] OCTET_BITS = 4'h8;
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam logic [7:0] WINDOW_RST = 8'h00;
  localparam logic [ONES_W-1:0] COUNT_RST = 4'h0;

endpackage

// ===== event_flag_bank.sv
// Bank of sticky event flags with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module event_flag_bank
#(
  parameter int WIDTH = link_event_pkg::FLAG_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] flags
);
  import link_event_pkg::*;

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("event_flag_bank needs at least one flag");
    end
  endgenerate

  // An event in the clearing cycle survives to the next read
  always_comb
  begin
    flags_nxt = (flags_r & ~clear_in) | set_in;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_r <= '0;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule
`default_nettype wire

// ===== hdlc_link_event_flags.sv
// Event flags, enables, serial abort and idle detection for the first data link
//
// How it works
// (R1) The end-of-message flag, status bit 3, sets on a complete message or a full buffer.
// (R2) The check-sequence fault flag, status bit 2, sets when a message check sequence is bad.
// (R3) The abort flag, status bit 1, sets whenever seven ones in a row arrive on the link.
// (R4) The idle flag, status bit 0, sets whenever the flag octet 0x7E arrives on the link.
// (R5) Software takes idle and end-of-message reported together as a whole message received.
// (R6) Each flag resets to 0, holds 1 after its event and is cleared by a read of status.
// (R7) Enable bit 6, reset 0, lets a transmit-begin event raise the interrupt.
// (R8) Enable bit 5, reset 0, lets a receive-begin event raise the interrupt.
// (R9) Enable bit 4, reset 0, lets a transmit-end event raise the interrupt.
// (R10) Enable bit 3, reset 0, lets a receive-end event raise the interrupt.
// (R11) Status bits 6, 5 and 4 are read-clear flags for transmit begin, receive begin, transmit end.
// (R12) Enable bit 2, reset 0, gates the check-sequence fault interrupt.
// (R13) Enable bits 1 and 0, reset 0, gate the abort and idle interrupts.
// (R14) The interrupt is high while any flag is set with its enable bit at 1.
`timescale 1ns/1ps
`default_nettype none
module hdlc_link_event_flags
#(
  parameter int AW = link_event_pkg::ADDR_W,
  parameter int DW = link_event_pkg::DATA_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [link_event_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [link_event_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [link_event_pkg::DATA_W-1:0] reg_rdata,
  input wire logic tx_begin_evt,
  input wire logic rx_begin_evt,
  input wire logic tx_end_evt,
  input wire logic rx_message_done,
  input wire logic rx_buffer_full,
  input wire logic rx_check_bad,
  input wire logic rx_abort_evt,
  input wire logic rx_idle_evt,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  output logic irq
);
  import link_event_pkg::*;

  generate
    if (AW != ADDR_W || DW != DATA_W)
    begin : g_bad_width
      $error("hdlc_link_event_flags supports only the package bus widths");
    end
  endgenerate

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] flags_to_word(input logic [FLAG_W-1:0] f);
    flags_to_word = {1'b0, f};
  endfunction

  // Register strobes
  logic status_rd;
  logic status_wr;
  logic enable_wr;
  logic ctrl_wr;

  always_comb
  begin
    status_rd = reg_read && addr_hit(reg_addr, STATUS_OFS);
    status_wr = reg_write && addr_hit(reg_addr, STATUS_OFS);
    enable_wr = reg_write && addr_hit(reg_addr, ENABLE_OFS);
    ctrl_wr = reg_write && addr_hit(reg_addr, DETECT_CTRL_OFS);
  end

  // Control registers
  logic [FLAG_W-1:0] link_event_enable_r;
  logic [FLAG_W-1:0] link_event_enable_nxt;
  logic detect_en_r;
  logic detect_en_nxt;

  always_comb
  begin
    link_event_enable_nxt = link_event_enable_r;
    detect_en_nxt = detect_en_r;
    // Enable bits written whole; bit 7 is reserved and dropped
    if (enable_wr)
    begin
      link_event_enable_nxt = reg_wdata[FLAG_W-1:0];
    end
    if (ctrl_wr)
    begin
      detect_en_nxt = reg_wdata[DETECT_EN_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // (R7) enables reset closed
      link_event_enable_r <= ENABLE_RST;
      detect_en_r <= DETECT_EN_RST;
    end
    else
    begin
      link_event_enable_r <= link_event_enable_nxt;
      detect_en_r <= detect_en_nxt;
    end
  end

  // Serial detector for abort runs and flag octets
  logic [7:0] window_r;
  logic [7:0] window_nxt;
  logic [ONES_W-1:0] ones_r;
  logic [ONES_W-1:0] ones_nxt;
  logic [ONES_W-1:0] fill_r;
  logic [ONES_W-1:0] fill_nxt;
  logic serial_abort;
  logic serial_idle;
  logic [7:0] shifted;

  always_comb
  begin
    window_nxt = window_r;
    ones_nxt = ones_r;
    fill_nxt = fill_r;
    serial_abort = 1'b0;
    serial_idle = 1'b0;
    shifted = {window_r[6:0], rx_bit};
    if (!detect_en_r)
    begin
      window_nxt = WINDOW_RST;
      ones_nxt = COUNT_RST;
      fill_nxt = COUNT_RST;
    end
    else if (rx_bit_valid)
    begin
      window_nxt = shifted;
      if (fill_r != OCTET_BITS)
      begin
        fill_nxt = fill_r + 4'h1;
      end
      if (rx_bit)
      begin
        // Counter saturates so a long run of ones aborts only once
        if (ones_r != ABORT_ONES)
        begin
          ones_nxt = ones_r + 4'h1;
        end
        // (R3) seventh one in a row
        serial_abort = (ones_r == ABORT_ONES - 4'h1);
      end
      else
      begin
        ones_nxt = COUNT_RST;
      end
      // (R4) flag octet in window
      serial_idle = (shifted == FLAG_OCTET) && (fill_r >= OCTET_BITS - 4'h1);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      window_r <= WINDOW_RST;
      ones_r <= COUNT_RST;
      fill_r <= COUNT_RST;
    end
    else
    begin
      window_r <= window_nxt;
      ones_r <= ones_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Event gathering
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clear;
  logic [FLAG_W-1:0] link_event_status;

  always_comb
  begin
    flag_set = '0;
    // (R11) begin and end of transfer flags
    flag_set[TX_BEGIN_BIT] = tx_begin_evt;
    flag_set[RX_BEGIN_BIT] = rx_begin_evt;
    flag_set[TX_END_BIT] = tx_end_evt;
    // (R1) complete message or full buffer
    flag_set[RX_END_BIT] = rx_message_done || rx_buffer_full;
    // (R2) bad check sequence
    flag_set[FCS_FAULT_BIT] = rx_check_bad;
    // (R3) abort from pin or serial detector
    flag_set[ABORT_BIT] = rx_abort_evt || serial_abort;
    // (R4) idle octet from pin or serial detector
    flag_set[IDLE_BIT] = rx_idle_evt || serial_idle;
  end

  // (R6) read clears all, write of one clears that bit
  always_comb
  begin
    flag_clear = '0;
    if (status_rd)
    begin
      flag_clear = '1;
    end
    else if (status_wr)
    begin
      flag_clear = reg_wdata[FLAG_W-1:0];
    end
  end

  // (R6) sticky flags with set winning over clear
  event_flag_bank #(
    .WIDTH(FLAG_W)
  ) u_flags (
    .clock(clock),
    .rst_n(rst_n),
    .set_in(flag_set),
    .clear_in(flag_clear),
    .flags(link_event_status)
  );

  // Read data, valid only in the cycle after the strobe
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = RDATA_RST;
    if (reg_read)
    begin
      unique case (reg_addr)
        STATUS_OFS:
        begin
          // Value before the clear, so no flag is seen twice or lost
          rdata_nxt = flags_to_word(link_event_status);
        end
        ENABLE_OFS:
        begin
          rdata_nxt = flags_to_word(link_event_enable_r);
        end
        DETECT_CTRL_OFS:
        begin
          rdata_nxt = {7'h00, detect_en_r};
        end
        DETECT_VIEW_OFS:
        begin
          rdata_nxt = window_r;
        end
        default:
        begin
          rdata_nxt = RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= RDATA_RST;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Interrupt request
  logic [FLAG_W-1:0] gated;

  always_comb
  begin
    // (R7) transmit begin gate
    gated[TX_BEGIN_BIT] = link_event_status[TX_BEGIN_BIT] && link_event_enable_r[TX_BEGIN_BIT];
    // (R8) receive begin gate
    gated[RX_BEGIN_BIT] = link_event_status[RX_BEGIN_BIT] && link_event_enable_r[RX_BEGIN_BIT];
    // (R9) transmit end gate
    gated[TX_END_BIT] = link_event_status[TX_END_BIT] && link_event_enable_r[TX_END_BIT];
    // (R10) receive end gate
    gated[RX_END_BIT] = link_event_status[RX_END_BIT] && link_event_enable_r[RX_END_BIT];
    // (R12) check fault gate
    gated[FCS_FAULT_BIT] = link_event_status[FCS_FAULT_BIT]
                           && link_event_enable_r[FCS_FAULT_BIT];
    // (R13) abort and idle gates
    gated[ABORT_BIT] = link_event_status[ABORT_BIT] && link_event_enable_r[ABORT_BIT];
    gated[IDLE_BIT] = link_event_status[IDLE_BIT] && link_event_enable_r[IDLE_BIT];
  end

  // (R14) level request from registered flags only, so it cannot glitch on inputs
  assign irq = |gated;

endmodule
`default_nettype wire

// ===== link_event_assertions.sv
// Checker for the data link event flag block
`timescale 1ns/1ps
`default_nettype none
module link_event_checker
  import link_event_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_begin_evt,
  input wire logic rx_begin_evt,
  input wire logic tx_end_evt,
  input wire logic rx_message_done,
  input wire logic rx_buffer_full,
  input wire logic rx_check_bad,
  input wire logic rx_abort_evt,
  input wire logic rx_idle_evt,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic irq
);
  logic [6:0] en_r, en_nxt, ev;
  logic det_r, det_nxt, st_rd, quiet;
  // Shadow of the enables, so irq can be tied to its cause
  always_comb
  begin
    en_nxt = en_r;
    det_nxt = det_r;
    if (reg_write && reg_addr == ENABLE_OFS)
      en_nxt = reg_wdata[6:0];
    if (reg_write && reg_addr == DETECT_CTRL_OFS)
      det_nxt = reg_wdata[DETECT_EN_BIT];
    ev = {tx_begin_evt, rx_begin_evt, tx_end_evt, rx_message_done | rx_buffer_full,
      rx_check_bad, rx_abort_evt, rx_idle_evt};
    st_rd = reg_read && reg_addr == STATUS_OFS;
    quiet = ev == 7'h00 && !rx_bit_valid && !reg_write;
  end
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      en_r <= ENABLE_RST;
      det_r <= DETECT_EN_RST;
    end
    else
    begin
      en_r <= en_nxt;
      det_r <= det_nxt;
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_event_raises_irq: assert property (
    (ev & en_r) != 7'h00 && !(reg_write && reg_addr == ENABLE_OFS) |=> irq)
    else $error("enabled event gave no irq");
  a_irq_needs_enable: assert property (en_r == 7'h00 |-> !irq)
    else $error("irq with all enables low");
  a_read_drops_irq: assert property (st_rd && quiet |=> !irq)
    else $error("irq stayed after status read");
  a_txend_reported: assert property (tx_end_evt ##1 st_rd |=> reg_rdata[TX_END_BIT])
    else $error("transmit end flag lost");
  a_full_sets_end: assert property (rx_buffer_full ##1 st_rd |=> reg_rdata[RX_END_BIT])
    else $error("buffer full did not set end flag");
  a_abort_after_seven: assert property (
    (det_r && rx_bit_valid && rx_bit)[*7] ##1 st_rd |=> reg_rdata[ABORT_BIT])
    else $error("seven ones gave no abort flag");
  a_bit7_reads_zero: assert property (
    reg_read && (st_rd || reg_addr == ENABLE_OFS) |=> !reg_rdata[7])
    else $error("bit 7 read as one");
  a_enable_readback: assert property (
    reg_write && reg_addr == ENABLE_OFS ##1 reg_read && reg_addr == ENABLE_OFS
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7F))
    else $error("enable readback wrong");
  c_read_clear: cover property (st_rd && quiet);
  c_irq: cover property (irq);
  c_ones_run: cover property ((rx_bit_valid && rx_bit)[*7]);
  c_tight_read: cover property (tx_end_evt ##1 st_rd);
endmodule
bind hdlc_link_event_flags link_event_checker link_event_checker_inst (.clock(clock),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_begin_evt(tx_begin_evt),
  .rx_begin_evt(rx_begin_evt), .tx_end_evt(tx_end_evt), .rx_message_done(rx_message_done),
  .rx_buffer_full(rx_buffer_full), .rx_check_bad(rx_check_bad), .rx_abort_evt(rx_abort_evt),
  .rx_idle_evt(rx_idle_evt), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .irq(irq));
`default_nettype wire

// ===== hdlc_link_event_flags_tb.sv
// Self-checking bench for the data link event flag block
`timescale 1ns/1ps
`default_nettype none
module hdlc_link_event_flags_tb;
  import link_event_pkg::*;
  logic clock, rst_n, reg_write, reg_read, rx_bit, rx_bit_valid, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, evt, d;
  int err_count, n_checks;
  hdlc_link_event_flags hdlc_link_event_flags_inst (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_begin_evt(evt[6]), .rx_begin_evt(evt[5]), .tx_end_evt(evt[4]),
    .rx_message_done(evt[3]), .rx_buffer_full(evt[7]), .rx_check_bad(evt[2]),
    .rx_abort_evt(evt[1]), .rx_idle_evt(evt[0]), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .irq(irq));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    evt <= 8'h01 << i;
    @(posedge clock);
    evt <= 8'h00;
    #1;
  endtask
  task automatic send(input logic [7:0] v, input int n);
    for (int k = 7; k > 7 - n; k--)
    begin
      @(posedge clock);
      rx_bit_valid <= 1'b1;
      rx_bit <= v[k];
    end
    @(posedge clock);
    rx_bit_valid <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rd(STATUS_OFS);
    chk(d, 8'h00);
    rd(ENABLE_OFS);
    chk(d, 8'h00);
    rd(DETECT_CTRL_OFS);
    chk(d, 8'h01);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_regs;
    wr(ENABLE_OFS, 8'hFF);
    rd(ENABLE_OFS);
    chk(d, 8'h7F);
    rd(8'h3C);
    chk(d, 8'h00);
  endtask
  // Index 7 is the buffer-full cause, which shares the end-of-message flag
  task automatic t_events;
    int b;
    for (int i = 0; i < 8; i++)
    begin
      b = (i == 7) ? 3 : i;
      wr(ENABLE_OFS, 8'h01 << b);
      pulse(i);
      chk({7'h00, irq}, 8'h01);
      rd(STATUS_OFS);
      chk(d, 8'h01 << b);
      chk({7'h00, irq}, 8'h00);
      wr(ENABLE_OFS, ~(8'h01 << b) & 8'h7F);
      pulse(i);
      chk({7'h00, irq}, 8'h00);
      rd(STATUS_OFS);
      chk(d, 8'h01 << b);
    end
  endtask
  // A set in the same cycle as the clearing read must survive it
  task automatic t_collide;
    fork
      rd(STATUS_OFS);
      pulse(2);
    join
    chk(d, 8'h00);
    rd(STATUS_OFS);
    chk(d, 8'h04);
    pulse(0);
    wr(STATUS_OFS, 8'h01);
    rd(STATUS_OFS);
    chk(d, 8'h00);
  endtask
  task automatic t_serial;
    wr(ENABLE_OFS, 8'h02);
    send(8'hFE, 7);
    chk({7'h00, irq}, 8'h01);
    rd(STATUS_OFS);
    chk(d, 8'h02);
    send(8'h7E, 8);
    rd(STATUS_OFS);
    chk(d, 8'h01);
  endtask
  // Read straight after the event, with no idle cycle between
  task automatic pulse_rd(input logic [7:0] e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= 8'h00;
    reg_read <= 1'b1;
    reg_addr <= STATUS_OFS;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic t_tight;
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= ENABLE_OFS;
    reg_wdata <= 8'hA5;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    chk(d, 8'h25);
    pulse_rd(8'h10);
    chk(d, 8'h10);
    pulse_rd(8'h80);
    chk(d, 8'h08);
    // Idle and end of message reported together mean a whole message
    pulse_rd(8'h09);
    chk(d, 8'h09);
    @(posedge clock);
    rx_bit_valid <= 1'b1;
    rx_bit <= 1'b1;
    repeat (7) @(posedge clock);
    rx_bit_valid <= 1'b0;
    reg_read <= 1'b1;
    reg_addr <= STATUS_OFS;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    chk(d, 8'h02);
  endtask
  // Detector switched off must ignore the link and clear its window
  task automatic t_detect;
    wr(DETECT_CTRL_OFS, 8'h00);
    rd(DETECT_CTRL_OFS);
    chk(d, 8'h00);
    rd(DETECT_VIEW_OFS);
    chk(d, 8'h00);
    send(8'hFF, 8);
    rd(STATUS_OFS);
    chk(d, 8'h00);
    wr(DETECT_CTRL_OFS, 8'h01);
    rd(DETECT_CTRL_OFS);
    chk(d, 8'h01);
    send(8'h7E, 8);
    rd(STATUS_OFS);
    chk(d, 8'h01);
    rd(DETECT_VIEW_OFS);
    chk(d, 8'h7E);
  endtask
  task automatic t_midreset;
    wr(ENABLE_OFS, 8'h7F);
    pulse(6);
    chk({7'h00, irq}, 8'h01);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    chk({7'h00, irq}, 8'h00);
    @(posedge clock);
    rst_n <= 1'b1;
    rd(STATUS_OFS);
    chk(d, 8'h00);
    rd(ENABLE_OFS);
    chk(d, 8'h00);
  endtask
  initial
  begin
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    evt = 8'h00;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_events();
    t_collide();
    t_serial();
    t_tight();
    t_detect();
    t_midreset();
    report_and_stop();
  end
  initial
  begin
    #1000000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
